// File: design/cxe_exec.v
// cxe_exec.v: one-cycle executor for transfer, watchdog and ram exchange ops
// assumes: fetch presents a 10-bit word with valid each instruction cycle;
// register file, ram and peripherals take the _we/_out values next cycle.
// Contract
// - reload upper from B, lower from A
// - clock select op copies A to register
// - each irq op writes only its register
// - A copied into Y pointer
// - watchdog flag set: skip, clear flag
// - swap A with ram, X xor j
// - swap-dec also decrements Y mod sixteen
// - swap-dec skips next when Y is 15
// - swap-inc increments Y, skips on zero
// - D to A low three, A3 zero
// - Z to A low two, upper zero
// - stack pointer to A, A3 zero
// - E upper to B, lower to A
// - B, A into E upper, lower
// - immediate x to X, y to Y
// - consecutive pointer loads after first skipped
`default_nettype none
`include "cxe_consts.vh"
module cxe_exec #(
	parameter W = 4
) (
	input wire clk_in,
	input wire arst_n_in,
	input wire instr_valid_in,
	input wire [9:0] instr_in,
	input wire [W-1:0] acc_in,
	input wire [W-1:0] breg_in,
	input wire [W-1:0] xreg_in,
	input wire [W-1:0] yreg_in,
	input wire [2:0] dreg_in,
	input wire [1:0] zreg_in,
	input wire [2:0] stack_pointer_in,
	input wire [2*W-1:0] ereg_in,
	input wire [W-1:0] ram_rdata_in,
	input wire watchdog_flag_in,
	output reg acc_we_out,
	output reg [W-1:0] acc_out,
	output reg breg_we_out,
	output reg [W-1:0] breg_out,
	output reg xreg_we_out,
	output reg [W-1:0] xreg_out,
	output reg yreg_we_out,
	output reg [W-1:0] yreg_out,
	output reg ereg_we_out,
	output reg [2*W-1:0] ereg_out,
	output reg ram_we_out,
	output reg [W-1:0] ram_wdata_out,
	output reg watchdog_clr_out,
	output reg timer_one_reload_we_out,
	output reg [2*W-1:0] timer_one_reload_out,
	output reg clock_select_reg_we_out,
	output reg [1:0] irq_ctl_we_out,
	output reg [3:0] timer_ctl_we_out,
	output reg [W-1:0] periph_data_out,
	output reg exec_out,
	output reg skipped_out
);
	// carry is not a port at all, so nothing here can disturb it
	reg skip_q, skip_d;
	reg lxy_prev_q, lxy_prev_d;
	reg acc_we_d, breg_we_d, xreg_we_d, yreg_we_d, ereg_we_d, ram_we_d;
	reg [W-1:0] acc_d, breg_d, xreg_d, yreg_d, ram_d, per_d;
	reg [2*W-1:0] ereg_d, rel_d;
	reg wdc_d, rel_we_d, clk_we_d, exec_d, skd_d;
	reg [1:0] irq_we_d;
	reg [3:0] tmr_we_d;
	reg run;
	reg is_lxy;
	reg [W-1:0] y_new;

	localparam [W-1:0] NIB_ONE = {{(W-1){1'b0}}, 1'b1};
	localparam [W-1:0] NIB_ALL = {W{1'b1}};
	localparam [W-1:0] NIB_ZERO = {W{1'b0}};

	// six-bit prefix of the ram exchange family; j sits below it
	function [5:0] prefix6;
		input [9:0] w;
		begin
			prefix6 = w[`CXE_PRE_MSB:`CXE_PRE6_LSB];
		end
	endfunction

	function is_swap_dec;
		input [9:0] w;
		begin
			is_swap_dec = prefix6(w) == `CXE_PRE_SWAPD;
		end
	endfunction

	function is_swap_inc;
		input [9:0] w;
		begin
			is_swap_inc = prefix6(w) == `CXE_PRE_SWAPI;
		end
	endfunction

	function is_swap;
		input [9:0] w;
		begin
			is_swap = prefix6(w) == `CXE_PRE_SWAP ||
				is_swap_dec(w) || is_swap_inc(w);
		end
	endfunction

	// pointer loads are the only words with both top bits set
	function is_lxy_word;
		input [9:0] w;
		begin
			is_lxy_word = w[`CXE_PRE_MSB:`CXE_PRE2_LSB] == `CXE_PRE_LXY;
		end
	endfunction

	always @* begin
		is_lxy = is_lxy_word(instr_in);
		// a suppressed word still counts for the chain of pointer loads
		run = instr_valid_in && !skip_q && !(is_lxy && lxy_prev_q);

		// defaults: no strobe up, register outputs follow their inputs, ram, peripheral and reload data follow A and B
		acc_we_d = 1'b0;
		breg_we_d = 1'b0;
		xreg_we_d = 1'b0;
		yreg_we_d = 1'b0;
		ereg_we_d = 1'b0;
		ram_we_d = 1'b0;

		acc_d = acc_in;
		breg_d = breg_in;
		xreg_d = xreg_in;
		yreg_d = yreg_in;
		ereg_d = ereg_in;
		ram_d = acc_in;
		per_d = acc_in;
		rel_d = {breg_in, acc_in};

		wdc_d = 1'b0;
		rel_we_d = 1'b0;
		clk_we_d = 1'b0;
		irq_we_d = 2'b00;
		tmr_we_d = 4'b0000;

		y_new = yreg_in;
		skd_d = 1'b0;

		lxy_prev_d = instr_valid_in ? is_lxy : lxy_prev_q;
		// skip lasts exactly one valid word; a gap keeps it
		skip_d = instr_valid_in ? 1'b0 : skip_q;
		exec_d = run;
		if (run) begin
			case (instr_in)
			`CXE_OP_LOAD_TIMER_ONE_RELOAD_OP: rel_we_d = 1'b1;
			`CXE_OP_CLKSEL: clk_we_d = 1'b1;
			`CXE_OP_IRQ1: irq_we_d = 2'b01;
			`CXE_OP_IRQ2: irq_we_d = 2'b10;
			`CXE_OP_TMR1: tmr_we_d = 4'b0001;
			`CXE_OP_TMR2: tmr_we_d = 4'b0010;
			`CXE_OP_TMR3: tmr_we_d = 4'b0100;
			`CXE_OP_TMR4: tmr_we_d = 4'b1000;
			`CXE_OP_ACC2Y: begin
				yreg_we_d = 1'b1;
				yreg_d = acc_in;
			end
			`CXE_OP_WDRST: begin
				if (watchdog_flag_in) begin
					skip_d = 1'b1;
					wdc_d = 1'b1;
				end
			end
			`CXE_OP_D2A: begin
				acc_we_d = 1'b1;
				acc_d = {1'b0, dreg_in};
			end
			`CXE_OP_Z2A: begin
				acc_we_d = 1'b1;
				acc_d = {2'b00, zreg_in};
			end
			`CXE_OP_SP2A: begin
				acc_we_d = 1'b1;
				acc_d = {1'b0, stack_pointer_in};
			end
			`CXE_OP_E2A: begin
				acc_we_d = 1'b1;
				breg_we_d = 1'b1;
				{breg_d, acc_d} = ereg_in;
			end
			`CXE_OP_A2E: begin
				ereg_we_d = 1'b1;
				ereg_d = {breg_in, acc_in};
			end
			default: begin
				if (is_lxy) begin
					xreg_we_d = 1'b1;
					yreg_we_d = 1'b1;
					xreg_d = instr_in[`CXE_X_MSB:`CXE_X_LSB];
					yreg_d = instr_in[`CXE_J_MSB:0];
				end else if (is_swap(instr_in)) begin
					acc_we_d = 1'b1;
					ram_we_d = 1'b1;
					acc_d = ram_rdata_in;
					ram_d = acc_in;
					xreg_we_d = 1'b1;
					xreg_d = xreg_in ^ instr_in[`CXE_J_MSB:0];
					if (is_swap_dec(instr_in)) begin
						y_new = yreg_in - NIB_ONE;
						yreg_we_d = 1'b1;
						yreg_d = y_new;
						skip_d = y_new == NIB_ALL;
					end else if (is_swap_inc(instr_in)) begin
						y_new = yreg_in + NIB_ONE;
						yreg_we_d = 1'b1;
						yreg_d = y_new;
						skip_d = y_new == NIB_ZERO;
					end
				end else begin
					exec_d = 1'b0;
				end
			end
			endcase
		end else if (instr_valid_in) begin
			skd_d = 1'b1;
		end
	end

	// skip and pointer-load chain live apart from the strobes: they are
	// the only state that carries from one word to the next
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			skip_q <= 1'b0;
			lxy_prev_q <= 1'b0;
		end else begin
			skip_q <= skip_d;
			lxy_prev_q <= lxy_prev_d;
		end
	end

	// every strobe drops back after one cycle; data outputs follow the
	// inputs while no strobe is up, which keeps the muxes small
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_we_out <= 1'b0;
			acc_out <= `CXE_NIB_RST;
			breg_we_out <= 1'b0;
			breg_out <= `CXE_NIB_RST;
			xreg_we_out <= 1'b0;
			xreg_out <= `CXE_NIB_RST;
			yreg_we_out <= 1'b0;
			yreg_out <= `CXE_NIB_RST;
			ereg_we_out <= 1'b0;
			ereg_out <= `CXE_BYTE_RST;

			ram_we_out <= 1'b0;
			ram_wdata_out <= `CXE_NIB_RST;

			watchdog_clr_out <= 1'b0;
			timer_one_reload_we_out <= 1'b0;
			timer_one_reload_out <= `CXE_BYTE_RST;
			clock_select_reg_we_out <= 1'b0;
			irq_ctl_we_out <= 2'b00;
			timer_ctl_we_out <= 4'b0000;
			periph_data_out <= `CXE_NIB_RST;

			exec_out <= 1'b0;
			skipped_out <= 1'b0;
		end else begin
			// register file writeback
			acc_we_out <= acc_we_d;
			acc_out <= acc_d;
			breg_we_out <= breg_we_d;
			breg_out <= breg_d;
			xreg_we_out <= xreg_we_d;
			xreg_out <= xreg_d;
			yreg_we_out <= yreg_we_d;
			yreg_out <= yreg_d;
			ereg_we_out <= ereg_we_d;
			ereg_out <= ereg_d;

			// ram nibble writeback
			ram_we_out <= ram_we_d;
			ram_wdata_out <= ram_d;

			// peripheral control strobes
			watchdog_clr_out <= wdc_d;
			timer_one_reload_we_out <= rel_we_d;
			timer_one_reload_out <= rel_d;
			clock_select_reg_we_out <= clk_we_d;
			irq_ctl_we_out <= irq_we_d;
			timer_ctl_we_out <= tmr_we_d;
			periph_data_out <= per_d;

			// status of the word just taken
			exec_out <= exec_d;
			skipped_out <= skd_d;
		end
	end
endmodule
`default_nettype wire

// File: design/cxe_consts.vh
// cxe_consts.vh: opcodes and field positions of the transfer/exchange unit
// assumes: included by the executor; 10-bit instruction words
`ifndef CXE_CONSTS_VH
`define CXE_CONSTS_VH
`define CXE_OP_LOAD_TIMER_ONE_RELOAD_OP 10'h23F
`define CXE_OP_CLKSEL 10'h20D
`define CXE_OP_IRQ1 10'h03F
`define CXE_OP_IRQ2 10'h03E
`define CXE_OP_TMR1 10'h20E
`define CXE_OP_TMR2 10'h20F
`define CXE_OP_TMR3 10'h210
`define CXE_OP_TMR4 10'h211
`define CXE_OP_ACC2Y 10'h00C
`define CXE_OP_WDRST 10'h2A0
`define CXE_OP_D2A 10'h051
`define CXE_OP_Z2A 10'h053
`define CXE_OP_SP2A 10'h050
`define CXE_OP_E2A 10'h02A
`define CXE_OP_A2E 10'h01A
`define CXE_PRE_SWAP 6'h2D
`define CXE_PRE_SWAPD 6'h2F
`define CXE_PRE_SWAPI 6'h2E
`define CXE_PRE_LXY 2'h3
`define CXE_PRE_MSB 9
`define CXE_PRE6_LSB 4
`define CXE_PRE2_LSB 8
`define CXE_J_MSB 3
`define CXE_X_MSB 7
`define CXE_X_LSB 4
`define CXE_NIB_RST 4'h0
`define CXE_BYTE_RST 8'h00
`endif

// File: testbench/cxe_regs.sv
// cxe_regs.sv: register file, ram nibble and watchdog flag model
// assumes: strobes of the unit land on the next edge; one ram nibble
`default_nettype none
module cxe_regs (
	input wire logic clk_in, arst_n_in, wd_set_in, watchdog_clr_out,
	input wire logic acc_we_out, breg_we_out, xreg_we_out, yreg_we_out,
	input wire logic ram_we_out,
	input wire logic [3:0] acc_out, breg_out, xreg_out, yreg_out,
	input wire logic [3:0] ram_wdata_out,
	output logic [3:0] acc_in, breg_in, xreg_in, yreg_in, ram_rdata_in,
	output logic watchdog_flag_in
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{acc_in, breg_in, xreg_in, yreg_in, ram_rdata_in} <= 20'h0;
			watchdog_flag_in <= 1'b0;
		end else begin
			if (acc_we_out) acc_in <= acc_out;
			if (breg_we_out) breg_in <= breg_out;
			if (xreg_we_out) xreg_in <= xreg_out;
			if (yreg_we_out) yreg_in <= yreg_out;
			if (ram_we_out) ram_rdata_in <= ram_wdata_out;
			// set wins: a flag raised as the clear lands must survive
			if (wd_set_in) watchdog_flag_in <= 1'b1;
			else if (watchdog_clr_out) watchdog_flag_in <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: testbench/cxe_exec_asserts.sv
// cxe_exec_asserts.sv: port checks of the transfer and exchange unit
// assumes: bound to cxe_exec; strobes one cycle after the taking edge
`default_nettype none
module cxe_exec_asserts #(parameter W = 4) (
	input wire logic clk_in, arst_n_in, instr_valid_in, watchdog_clr_out,
	input wire logic [9:0] instr_in,
	input wire logic [W-1:0] acc_in, breg_in, yreg_in, ram_rdata_in,
	input wire logic [2:0] dreg_in,
	input wire logic acc_we_out, ram_we_out, yreg_we_out, skipped_out,
	input wire logic [W-1:0] acc_out, yreg_out, ram_wdata_out,
	input wire logic timer_one_reload_we_out,
	input wire logic [2*W-1:0] timer_one_reload_out,
	input wire logic [3:0] timer_ctl_we_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	reload_pair_a: assert property (instr_valid_in && instr_in == 10'h23F |=>
		skipped_out || timer_one_reload_we_out &&
		timer_one_reload_out == {$past(breg_in), $past(acc_in)})
		else $error("reload pair");
	timer_third_a: assert property (instr_valid_in && instr_in == 10'h210 |=>
		skipped_out || timer_ctl_we_out == 4'h4) else $error("timer strobe");
	wd_skip_a: assert property (watchdog_clr_out && !instr_valid_in
		##1 instr_valid_in |=> skipped_out) else $error("watchdog skip");
	dec_wrap_a: assert property (instr_valid_in && instr_in[9:4] == 6'h2F &&
		yreg_in == 4'h0 ##1 !skipped_out && !instr_valid_in
		##1 instr_valid_in |=> skipped_out) else $error("dec skip");
	inc_swap_a: assert property (instr_valid_in && instr_in[9:4] == 6'h2E |=>
		skipped_out || acc_out == $past(ram_rdata_in) && ram_wdata_out ==
		$past(acc_in) && yreg_out == $past(yreg_in) + 4'h1) else $error("inc swap");
	d_read_a: assert property (instr_valid_in && instr_in == 10'h051 |=>
		skipped_out || acc_we_out && acc_out == {1'b0, $past(dreg_in)})
		else $error("d read");
	lxy_chain_a: assert property (instr_valid_in && instr_in[9:8] == 2'h3
		##1 !instr_valid_in ##1 instr_valid_in && instr_in[9:8] == 2'h3
		|=> skipped_out) else $error("pointer chain");
	skip_quiet_a: assert property (skipped_out |->
		!(acc_we_out || ram_we_out || yreg_we_out)) else $error("skip strobe");
endmodule
bind cxe_exec cxe_exec_asserts #(.W(W)) u_cxe_exec_asserts (.*);
`default_nettype wire

// File: testbench/cxe_exec_tb.sv
// cxe_exec_tb.sv: self-checking bench of the transfer and exchange unit
// assumes: cxe_regs feeds registers, ram nibble and watchdog flag back
`default_nettype none
module cxe_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, arst_n_in = 0, instr_valid_in = 0, wd_set_in = 0;
	logic watchdog_flag_in, acc_we_out, breg_we_out, xreg_we_out, yreg_we_out;
	logic ereg_we_out, ram_we_out, watchdog_clr_out, exec_out, skipped_out;
	logic timer_one_reload_we_out, clock_select_reg_we_out;
	logic [1:0] irq_ctl_we_out, zreg_in = 2'h3;
	logic [2:0] dreg_in = 3'h7, stack_pointer_in = 3'h5;
	logic [3:0] acc_in, breg_in, xreg_in, yreg_in, ram_rdata_in, acc_out;
	logic [3:0] breg_out, xreg_out, yreg_out, ram_wdata_out, periph_data_out;
	logic [3:0] timer_ctl_we_out;
	logic [7:0] ereg_in = 8'h5A, ereg_out, timer_one_reload_out;
	logic [9:0] instr_in = 10'h000;
	int bad_count = 0, check_count = 0, cycles = 0;
	cxe_exec u_cxe_exec (.*);
	cxe_regs u_cxe_regs (.*);
	always #5 clk_in = ~clk_in;
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// whole run is under 200 cycles; the ceiling only cuts a hang
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// one gap cycle lets the model write back before the next word
	task automatic op(input logic [9:0] w, input logic s);
		@(posedge clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= w;
		@(posedge clk_in);
		instr_valid_in <= 1'b0;
		#1;
		chk("skipped", {7'h0, s}, {7'h0, skipped_out});
		chk("exec", {7'h0, !s}, {7'h0, exec_out});
	endtask
	task automatic s_pairs;
		op(10'h02A, 0);
		chk("breg", 8'h85, {breg_we_out, 3'h0, breg_out});
		chk("acc", 8'h8A, {acc_we_out, 3'h0, acc_out});
		op(10'h01A, 0);
		chk("ereg", 8'h5A, ereg_out);
		op(10'h23F, 0);
		chk("reload", 8'h5A, timer_one_reload_out);
		op(10'h20D, 0);
		chk("clksel", 8'h1A, {3'h0, clock_select_reg_we_out, periph_data_out});
		op(10'h03F, 0);
		chk("irq", 8'h01, {6'h0, irq_ctl_we_out});
		op(10'h03E, 0);
		chk("irq", 8'h02, {6'h0, irq_ctl_we_out});
		for (int k = 0; k < 4; k++) begin
			op(10'h20E + 10'(k), 0);
			chk("timer", 8'h01 << k, {4'h0, timer_ctl_we_out});
		end
		op(10'h00C, 0);
		chk("yreg", 8'h8A, {yreg_we_out, 3'h0, yreg_out});
	endtask
	task automatic s_narrow;
		op(10'h051, 0);
		chk("acc", 8'h87, {acc_we_out, 3'h0, acc_out});
		op(10'h053, 0);
		chk("acc", 8'h83, {acc_we_out, 3'h0, acc_out});
		op(10'h050, 0);
		chk("acc", 8'h85, {acc_we_out, 3'h0, acc_out});
	endtask
	task automatic s_swap;
		op(10'h3B0, 0);
		chk("xy", 8'hB0, {xreg_out, yreg_out});
		op(10'h3FF, 1);
		op(10'h2F6, 0);
		chk("swap", 8'h05, {acc_out, ram_wdata_out});
		chk("xy", 8'hDF, {xreg_out, yreg_out});
		op(10'h03F, 1);
		op(10'h2E1, 0);
		chk("swap", 8'h50, {acc_out, ram_wdata_out});
		chk("xy", 8'hC0, {xreg_out, yreg_out});
		op(10'h03F, 1);
		op(10'h2D3, 0);
		chk("swap", 8'h05, {acc_out, ram_wdata_out});
		chk("xwe", 8'hF6, {xreg_out, 1'b0, ram_we_out, xreg_we_out, yreg_we_out});
		op(10'h03F, 0);
	endtask
	task automatic s_misc;
		@(posedge clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= 10'h000;
		@(posedge clk_in);
		instr_in <= 10'h2F0;
		#1;
		chk("unknown", 8'h00, {skipped_out, exec_out, acc_we_out, ram_we_out, 4'h0});
		@(posedge clk_in);
		instr_in <= 10'h03F;
		#1;
		chk("xy", 8'hFF, {xreg_out, yreg_out});
		@(posedge clk_in);
		instr_valid_in <= 1'b0;
		#1;
		chk("b2b", 8'h01, {exec_out, irq_ctl_we_out, 4'h0, skipped_out});
		op(10'h2E0, 0);
		@(posedge clk_in);
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
		op(10'h03F, 0);
	endtask
	task automatic s_wd;
		op(10'h2A0, 0);
		chk("wdclr", 8'h00, {7'h0, watchdog_clr_out});
		op(10'h03F, 0);
		@(posedge clk_in);
		wd_set_in <= 1'b1;
		@(posedge clk_in);
		wd_set_in <= 1'b0;
		op(10'h2A0, 0);
		chk("wdclr", 8'h01, {7'h0, watchdog_clr_out});
		op(10'h03F, 1);
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		s_pairs();
		s_narrow();
		s_swap();
		s_wd();
		s_misc();
		complete_run();
	end
endmodule
`default_nettype wire
